// ===== testbench/sr_ctrl_model.sv
// Memory controller model driving CKE, ODT and the command pins
`timescale 1ns/1ps
module sr_ctrl_model (
  input wire logic i_clk,
  output logic o_cke,
  output logic [4:0] o_cmd_b,
  output logic o_odt
);
  // ****************************************
  // State
  // ****************************************
  localparam int CKESR_CYC = 5; // Residency before exit, above the minimum
  logic asleep = 1'b0;
  initial begin
    o_cke = 1'b1;
    o_cmd_b = 5'h1f;
    o_odt = 1'b0;
  end

  // Pins wander while the device sleeps, it must not look at them
  always @(posedge i_clk) begin
    if (asleep) begin
      o_cmd_b <= ~o_cmd_b;
      o_odt <= ~o_odt;
    end
  end

  // ****************************************
  // Command sequences
  // ****************************************
  // Idle cycles with Deselect and CKE high, clock left running
  task automatic idle(input int n, input logic odt);
    repeat (n) begin
      @(posedge i_clk);
      o_cke <= 1'b1;
      o_cmd_b <= 5'h1f;
      o_odt <= odt;
    end
  endtask

  // Entry from idle: Deselect, entry command, Deselect, CKE held low
  task automatic enter();
    idle(1, o_odt);
    @(posedge i_clk);
    o_cke <= 1'b0;
    o_cmd_b <= 5'h09;
    @(posedge i_clk);
    o_cmd_b <= 5'h1f;
    @(posedge i_clk);
    asleep <= 1'b1;
    repeat (CKESR_CYC) @(posedge i_clk);
  endtask

  // Exit: pins settle first so no edge carries two drivers
  task automatic leave();
    @(posedge i_clk);
    asleep <= 1'b0;
    @(posedge i_clk);
    o_cke <= 1'b1;
    o_cmd_b <= 5'h1f;
    o_odt <= 1'b0;
  endtask

  // One refresh command, only called well after the exit window
  task automatic refresh();
    @(posedge i_clk);
    o_cmd_b <= 5'h09;
    @(posedge i_clk);
    o_cmd_b <= 5'h1f;
  endtask
endmodule

// ===== testbench/sr_self_refresh_bench.sv
// Self-checking bench of the self-refresh sequencer
`timescale 1ns/1ps
module sr_self_refresh_bench;
  import sr_pkg::*;
  // ****************************************
  // Signals and table
  // ****************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hot = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rdata;
  logic [31:0] v;
  logic hready, hresp, sref, term, park, dll_en, dll_rst, lock, vpwr, vstab;
  logic cmdv, int_ref, abort, cke, odt;
  logic [4:0] cmd_b;
  sr_mode_t mode;
  int failures = 0;
  int n_checks = 0;
  int cmd_seen = 0;
  int n, g, s;
  typedef struct {
    logic [5:0] ctrl;
    logic hot;
    int gap;
    int stab;
  } row_s;
  row_s rows [7] = '{'{6'h03, 1'b0, 78, 3}, '{6'h17, 1'b0, 156, 0}, '{6'h23, 1'b0, 39, 3},
    '{6'h33, 1'b0, 156, 3}, '{6'h33, 1'b1, 39, 3}, '{6'h0b, 1'b0, 78, 2},
    '{6'h00, 1'b0, 78, 3}};

  sr_ctrl_model ctl (.i_clk(clk), .o_cke(cke), .o_cmd_b(cmd_b), .o_odt(odt));
  sr_self_refresh dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_CKE(cke),
    .I_CS_B(cmd_b[4]), .I_ACT_B(cmd_b[3]), .I_RAS_B(cmd_b[2]), .I_CAS_B(cmd_b[1]),
    .I_WE_B(cmd_b[0]), .I_ODT(odt), .I_TEMP_HOT(hot), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(rdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .O_SR_MODE(mode), .O_SELF_REFRESH(sref), .O_ODT_TERM_EN(term), .O_PARK_EN(park),
    .O_DLL_EN(dll_en), .O_DLL_RESET(dll_rst), .O_DLL_LOCKED(lock), .O_VREFDQ_PWR(vpwr),
    .O_VREFDQ_STABLE(vstab), .O_CMD_VALID(cmdv), .O_INT_REFRESH(int_ref),
    .O_REFRESH_ABORT(abort));

  // Clock at 10 MHz
  initial begin
    forever #50 clk = ~clk;
  end

  // Counts accepted commands once outputs settle
  always @(posedge clk) begin
    #1;
    if (cmdv === 1'b1) cmd_seen++;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic complete_run();
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // One edge of a bounded wait
  task automatic tick(inout int k);
    @(posedge clk);
    k++;
    if (k > 500) begin
      failures++;
      complete_run();
    end
  endtask

  function automatic bit seen(input int sel);
    case (sel)
      1: return sref === 1'b0;
      2: return int_ref === 1'b1;
      3: return vstab === 1'b1;
      default: return lock === 1'b1;
    endcase
  endfunction

  task automatic wait_out(input int sel, output int k);
    k = 0;
    while (!seen(sel)) begin
      tick(k);
      #1;
    end
  endtask

  // Single AHB-Lite word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    tick(k);
    while (hready !== 1'b1) tick(k);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    tick(k);
    while (hready !== 1'b1) tick(k);
    v = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(v === e, "read data");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(hready === 1'b1 && hresp === 1'b0 && sref === 1'b0 && dll_en === 1'b1, "reset");
    rd_chk(8'h00, 32'h1);
    ahb(1'b1, 8'h04, 32'hff);
    rd_chk(8'h04, 32'h14);
    rd_chk(8'h0c, 32'h0);
    foreach (rows[i]) begin
      ahb(1'b1, 8'h00, {26'h0, rows[i].ctrl});
      hot <= rows[i].hot;
      ctl.idle(4, 1'b1);
      #1;
      chk(term === 1'b1, "termination before entry");
      ctl.enter();
      cmd_seen = 0;
      #1;
      chk(sref === 1'b1 && mode === rows[i].ctrl[5:4], "entry");
      chk(term === 1'b0 && park === 1'b0 && dll_en === !rows[i].ctrl[0] &&
        lock === !rows[i].ctrl[0], "off");
      chk(vpwr === rows[i].ctrl[2], "reference power");
      wait_out(2, n);
      tick(n);
      #1;
      wait_out(2, g);
      chk(g + 1 == rows[i].gap && sref === 1'b1, "interval");
      ctl.leave();
      wait_out(1, n);
      chk(dll_rst === rows[i].ctrl[0] && dll_en === rows[i].ctrl[0] &&
        park === rows[i].ctrl[1], "exit");
      chk(abort === rows[i].ctrl[3], "abort pulse");
      wait_out(3, s);
      chk(s == rows[i].stab, "reference settle");
      wait_out(4, n);
      if (!rows[i].ctrl[3]) chk(s + n == (rows[i].ctrl[0] ? 16 : s), "lock time");
      chk(cmd_seen == 0, "pins while asleep");
      ctl.refresh();
      ctl.idle(4, 1'b0);
      #1;
      chk(cmd_seen == 1, "command after exit");
      // Three refreshes finish in the first residency, none in flight at exit
      if (i == 0) rd_chk(8'h08, 32'h3);
    end
    // Clock enable low freezes a pending exit; reset still drops the state
    ctl.idle(4, 1'b0);
    ctl.enter();
    ce <= 1'b0;
    ctl.leave();
    ctl.idle(6, 1'b0);
    #1;
    chk(sref === 1'b1 && int_ref === 1'b0, "clock enable freeze");
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    chk(sref === 1'b0 && dll_en === 1'b1 && lock === 1'b1, "second reset");
    @(posedge clk);
    rst_b <= 1'b1;
    ce <= 1'b1;
    rd_chk(8'h00, 32'h1);
    complete_run();
  end
endmodule

// ===== verilog/refresh_if.sv
// Link between the sequencer and its internal refresh engine
`timescale 1ns/1ps
interface refresh_if;
  logic run;
  logic abort;
  logic ce;
  logic [7:0] interval;
  logic busy;
  logic pulse;
  logic [15:0] count;
  modport ctrl(output run, abort, ce, interval, input busy, pulse, count);
  modport engine(input run, abort, ce, interval, output busy, pulse, count);
endinterface

// ===== verilog/sr_map.svh
// Offsets, field positions, reset values and timing counts of the self-refresh block
`ifndef SR_MAP_SVH
`define SR_MAP_SVH

// Clock and timing figures, times in ns
`define CLK_PERIOD_NS 100
`define T_RFC_NS 260
`define T_XS_EXTRA_NS 10
`define T_XS_NS (`T_RFC_NS + `T_XS_EXTRA_NS)
`define T_REFI_NS 7800
`define RFC_CYC ((`T_RFC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define XS_CYC ((`T_XS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define XS_ABORT_CYC 2
`define XSDLL_CYC 16
`define REFI_CYC (`T_REFI_NS / `CLK_PERIOD_NS)
`define REFI_SLOW_CYC (`REFI_CYC * 2)
`define REFI_FAST_CYC (`REFI_CYC / 2)

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_REFCNT 8'h08

// Control fields
`define CTRL_DLL_ON 0
`define CTRL_PARK_EN 1
`define CTRL_VREF_KEEP 2
`define CTRL_ABORT_EN 3
`define CTRL_MODE_LSB 4
`define CTRL_MODE_MSB 5
`define CTRL_RST 6'h01

// Pin positions in the synchroniser vector
`define PIN_CKE 0
`define PIN_CS_B 1
`define PIN_ACT_B 2
`define PIN_RAS_B 3
`define PIN_CAS_B 4
`define PIN_WE_B 5
`define PIN_ODT 6
`define PIN_HOT 7

`endif

// ===== verilog/sr_pkg.sv
// Types shared by the self-refresh block
package sr_pkg;

  typedef enum logic [1:0] {ST_NORMAL, ST_SELF_REF, ST_EXIT_XS, ST_EXIT_DLL} sr_state_e;
  typedef logic [1:0] sr_mode_t;

  // State of the internal refresh engine
  typedef struct packed {
    logic [7:0] gap;
    logic [1:0] rfc;
    logic busy;
    logic pulse;
    logic running;
    logic [15:0] count;
  } eng_s;

  // State of the sequencer top
  typedef struct packed {
    logic [7:0] pin_m;
    logic [7:0] pin_s;
    logic cke_d;
    sr_state_e st;
    logic [7:0] cnt;
    logic [7:0] dll_cnt;
    logic [5:0] ctrl;
    sr_mode_t mode_act;
    logic abort_act;
    logic dll_act;
    logic in_sr;
    logic odt_term;
    logic park;
    logic dll_en;
    logic dll_rst;
    logic dll_lock;
    logic vref_pwr;
    logic vref_ok;
    logic cmd_ok;
    logic ref_abort;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic hready;
    logic hresp;
  } top_s;

endpackage

// ===== verilog/sr_refresh_engine.sv
// Internal refresh timer running while the device sits in self-refresh
`timescale 1ns/1ps
`include "sr_map.svh"
module sr_refresh_engine (
  input wire logic i_clk,
  input wire logic i_rst_b,
  refresh_if.engine rif
);
  import sr_pkg::*;

  eng_s s_r;
  eng_s s_nxt;

  // Refresh timing and abort handling
  always_comb begin
    s_nxt = s_r;
    s_nxt.pulse = 1'b0;
    // A refresh in flight ends, or is cut short without counting
    if (s_r.busy) begin
      if (rif.abort) begin
        s_nxt.busy = 1'b0;
      end else if (s_r.rfc == 2'h0) begin
        s_nxt.busy = 1'b0;
        s_nxt.count = s_r.count + 16'h1;
      end else begin
        s_nxt.rfc = s_r.rfc - 2'h1;
      end
    end
    // First refresh starts at once, the rest follow the interval
    if (rif.run) begin
      if (!s_r.running || s_r.gap == 8'h0) begin
        s_nxt.running = 1'b1;
        s_nxt.gap = rif.interval - 8'h1;
        if (!s_r.busy) begin
          s_nxt.busy = 1'b1;
          s_nxt.rfc = 2'(`RFC_CYC - 1);
          s_nxt.pulse = 1'b1;
        end
      end else begin
        s_nxt.gap = s_r.gap - 8'h1;
      end
    end else begin
      s_nxt.running = 1'b0;
      s_nxt.gap = 8'h0;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r <= '0;
    end else if (rif.ce) begin
      s_r <= s_nxt;
    end
  end

  assign rif.busy = s_r.busy;
  assign rif.pulse = s_r.pulse;
  assign rif.count = s_r.count;

endmodule

// ===== verilog/sr_self_refresh.sv
// Self-refresh entry, residency and exit sequencer with its register slave
`timescale 1ns/1ps
`include "sr_map.svh"
module sr_self_refresh (
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic I_CE,
  input wire logic I_CKE,
  input wire logic I_CS_B,
  input wire logic I_ACT_B,
  input wire logic I_RAS_B,
  input wire logic I_CAS_B,
  input wire logic I_WE_B,
  input wire logic I_ODT,
  input wire logic I_TEMP_HOT,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output sr_pkg::sr_mode_t O_SR_MODE,
  output logic O_SELF_REFRESH,
  output logic O_ODT_TERM_EN,
  output logic O_PARK_EN,
  output logic O_DLL_EN,
  output logic O_DLL_RESET,
  output logic O_DLL_LOCKED,
  output logic O_VREFDQ_PWR,
  output logic O_VREFDQ_STABLE,
  output logic O_CMD_VALID,
  output logic O_INT_REFRESH,
  output logic O_REFRESH_ABORT
);
  import sr_pkg::*;

  localparam int XSDLL_MAX = `XSDLL_CYC + 2;

  top_s s_r;
  top_s s_nxt;
  refresh_if rif ();

  logic cke;
  logic cs_b;
  logic act_b;
  logic ras_b;
  logic cas_b;
  logic we_b;
  logic odt;
  logic hot;
  logic awake;
  logic sre_cmd;
  logic entry_w;
  logic exit_w;
  logic any_cmd;
  logic addr_ok;
  logic [7:0] reg_addr;
  logic [7:0] interval;
  logic [31:0] status;
  logic [31:0] rd_mux;

  // ****************************************************************
  // Pin decode
  // ****************************************************************

  // Only the second synchroniser stage is read
  assign cke = s_r.pin_s[`PIN_CKE];
  assign cs_b = s_r.pin_s[`PIN_CS_B];
  assign act_b = s_r.pin_s[`PIN_ACT_B];
  assign ras_b = s_r.pin_s[`PIN_RAS_B];
  assign cas_b = s_r.pin_s[`PIN_CAS_B];
  assign we_b = s_r.pin_s[`PIN_WE_B];
  assign odt = s_r.pin_s[`PIN_ODT];
  assign hot = s_r.pin_s[`PIN_HOT];

  // Commands are only decoded outside self-refresh and tXS; in self-refresh only CKE and CS_B are looked at, for exit
  assign awake = (s_r.st == ST_NORMAL) || (s_r.st == ST_EXIT_DLL);
  assign sre_cmd = !cs_b && act_b && !ras_b && !cas_b && we_b;
  assign entry_w = awake && s_r.cke_d && !cke && sre_cmd;
  assign exit_w = (s_r.st == ST_SELF_REF) && cke && cs_b;
  assign any_cmd = awake && s_r.cke_d && cke && !cs_b;

  // ****************************************************************
  // Register bus
  // ****************************************************************

  // Address phase qualifier
  assign addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign reg_addr = I_HADDR[7:0];

  // Status word
  always_comb begin
    status = 32'h0;
    status[0] = s_r.in_sr;
    status[1] = (s_r.st == ST_EXIT_XS);
    status[2] = s_r.dll_lock;
    status[3] = rif.busy;
    status[4] = s_r.vref_ok;
    status[6:5] = s_r.mode_act;
  end

  // Read data selection, unmapped reads give zero
  always_comb begin
    case (reg_addr)
      `REG_CTRL: rd_mux = {26'h0, s_r.ctrl};
      `REG_STATUS: rd_mux = status;
      `REG_REFCNT: rd_mux = {16'h0, rif.count};
      default: rd_mux = 32'h0;
    endcase
  end

  // ****************************************************************
  // Refresh rate
  // ****************************************************************

  // Interval for the mode latched at entry
  always_comb begin
    case (s_r.mode_act)
      2'b01: interval = 8'(`REFI_SLOW_CYC);
      2'b10: interval = 8'(`REFI_FAST_CYC);
      2'b11: interval = hot ? 8'(`REFI_FAST_CYC) : 8'(`REFI_SLOW_CYC);
      default: interval = 8'(`REFI_CYC);
    endcase
  end

  assign rif.run = s_r.in_sr;
  assign rif.abort = s_r.ref_abort;
  assign rif.ce = I_CE;
  assign rif.interval = interval;

  sr_refresh_engine u_eng (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .rif(rif)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  // Next state of synchronisers, bus slave and self-refresh sequence
  always_comb begin
    s_nxt = s_r;
    s_nxt.pin_m = {I_TEMP_HOT, I_ODT, I_WE_B, I_CAS_B, I_RAS_B, I_ACT_B, I_CS_B, I_CKE};
    s_nxt.pin_s = s_r.pin_m;
    s_nxt.cke_d = cke;
    s_nxt.dll_rst = 1'b0;
    s_nxt.ref_abort = 1'b0;
    s_nxt.cmd_ok = any_cmd;
    s_nxt.odt_term = odt && (s_r.st == ST_NORMAL) && !entry_w;
    // Write data lands one cycle after its address phase
    s_nxt.wr_pend = addr_ok && I_HWRITE;
    s_nxt.wr_addr = reg_addr;
    if (s_r.wr_pend && s_r.wr_addr == `REG_CTRL) begin
      s_nxt.ctrl = I_HWDATA[5:0];
    end
    if (addr_ok && !I_HWRITE) begin
      s_nxt.rdata = rd_mux;
    end
    case (s_r.st)
      ST_NORMAL, ST_EXIT_DLL: begin
        if (entry_w) begin
          s_nxt.st = ST_SELF_REF;
          s_nxt.in_sr = 1'b1;
          s_nxt.mode_act = s_r.ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
          s_nxt.abort_act = s_r.ctrl[`CTRL_ABORT_EN];
          s_nxt.dll_act = s_r.ctrl[`CTRL_DLL_ON];
          s_nxt.odt_term = 1'b0;
          s_nxt.park = 1'b0;
          s_nxt.vref_pwr = s_r.ctrl[`CTRL_VREF_KEEP];
          s_nxt.vref_ok = s_r.ctrl[`CTRL_VREF_KEEP];
          if (s_r.ctrl[`CTRL_DLL_ON]) begin
            s_nxt.dll_en = 1'b0;
            s_nxt.dll_lock = 1'b0;
          end
        end else if (s_r.st == ST_EXIT_DLL) begin
          if (s_r.dll_cnt == 8'h0) begin
            s_nxt.dll_lock = 1'b1;
            s_nxt.st = ST_NORMAL;
          end else begin
            s_nxt.dll_cnt = s_r.dll_cnt - 8'h1;
          end
        end
      end
      ST_SELF_REF: begin
        // Of the memory pins, only CKE and CS_B are looked at here
        if (exit_w) begin
          s_nxt.st = ST_EXIT_XS;
          s_nxt.in_sr = 1'b0;
          s_nxt.cnt = s_r.abort_act ? 8'(`XS_ABORT_CYC - 1) : 8'(`XS_CYC - 1);
          s_nxt.dll_cnt = 8'(`XSDLL_CYC - 1);
          s_nxt.dll_en = s_r.dll_act;
          s_nxt.dll_rst = s_r.dll_act;
          s_nxt.park = s_r.ctrl[`CTRL_PARK_EN];
          s_nxt.vref_pwr = 1'b1;
          s_nxt.ref_abort = s_r.abort_act;
        end
      end
      ST_EXIT_XS: begin
        if (s_r.dll_cnt != 8'h0) begin
          s_nxt.dll_cnt = s_r.dll_cnt - 8'h1;
        end
        if (s_r.cnt == 8'h0) begin
          s_nxt.vref_ok = 1'b1;
          s_nxt.st = s_r.dll_act ? ST_EXIT_DLL : ST_NORMAL;
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h1;
        end
      end
      default: begin
        s_nxt.st = ST_NORMAL;
      end
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s_r <= '0;
      s_r.ctrl <= `CTRL_RST;
      s_r.dll_en <= 1'b1;
      s_r.dll_lock <= 1'b1;
      s_r.vref_pwr <= 1'b1;
      s_r.vref_ok <= 1'b1;
      s_r.hready <= 1'b1;
    end else if (I_CE) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // All outputs are flip-flop fields
  assign O_HRDATA = s_r.rdata;
  assign O_HREADYOUT = s_r.hready;
  assign O_HRESP = s_r.hresp;
  assign O_SR_MODE = s_r.mode_act;
  assign O_SELF_REFRESH = s_r.in_sr;
  assign O_ODT_TERM_EN = s_r.odt_term;
  assign O_PARK_EN = s_r.park;
  assign O_DLL_EN = s_r.dll_en;
  assign O_DLL_RESET = s_r.dll_rst;
  assign O_DLL_LOCKED = s_r.dll_lock;
  assign O_VREFDQ_PWR = s_r.vref_pwr;
  assign O_VREFDQ_STABLE = s_r.vref_ok;
  assign O_CMD_VALID = s_r.cmd_ok;
  assign O_INT_REFRESH = rif.pulse;
  assign O_REFRESH_ABORT = s_r.ref_abort;

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_B || !I_CE);

  sequence exit_normal_s;
    exit_w && !s_r.abort_act;
  endsequence

  sequence exit_abort_s;
    exit_w && s_r.abort_act;
  endsequence

  sequence exit_dll_s;
    exit_w && s_r.dll_act;
  endsequence

  sr_entry_a: assert property (entry_w |=> s_r.in_sr && s_r.st == ST_SELF_REF)
    else $error("entry command not taken");

  odt_off_a: assert property (entry_w |=> !s_r.odt_term && !s_r.park)
    else $error("termination left on in self-refresh");

  park_back_a: assert property (exit_w && s_r.ctrl[`CTRL_PARK_EN] |=> s_r.park)
    else $error("park termination not restored");

  dll_relock_a: assert property (
    exit_dll_s |=> s_r.dll_en && s_r.dll_rst ##1 !s_r.dll_rst ##[1:XSDLL_MAX] s_r.dll_lock)
    else $error("DLL not reset and relocked after exit");

  cmd_ignore_a: assert property (s_r.st == ST_SELF_REF |=> !s_r.cmd_ok)
    else $error("command accepted in self-refresh");

  vref_ready_a: assert property (exit_normal_s |=> ##[0:3] s_r.vref_ok)
    else $error("DQ reference not stable within tXS");

  first_ref_a: assert property (entry_w |=> ##1 rif.pulse)
    else $error("no internal refresh after entry");

  xs_wait_a: assert property (
    exit_normal_s |=> (s_r.st == ST_EXIT_XS) [*3] ##1 (s_r.st != ST_EXIT_XS))
    else $error("tXS window length wrong");

  abort_short_a: assert property (
    exit_abort_s |=> s_r.ref_abort && s_r.st == ST_EXIT_XS
      ##1 $stable(rif.count) && s_r.st == ST_EXIT_XS ##1 s_r.st != ST_EXIT_XS)
    else $error("abort exit wrong");

  adapt_rate_a: assert property (
    s_r.in_sr && s_r.mode_act == 2'b11 && hot |-> interval == 8'(`REFI_FAST_CYC))
    else $error("adaptive rate not raised when hot");

  mode_hold_a: assert property (s_r.in_sr && $past(s_r.in_sr) |-> $stable(s_r.mode_act))
    else $error("refresh mode changed in self-refresh");

  flag_clear_a: assert property (exit_w |=> !s_r.in_sr && !$past(s_r.in_sr) == 1'b0)
    else $error("self-refresh flag not cleared on exit");

endmodule
